// ---- smr_top.sv ----
/*
  Result registers, current and power arithmetic, conversion sequencing
  and alert logic of a shunt current and power monitor.
  Assumes a two-wire protocol engine on LNK_CLK presents one register
  access at a time, and an on-chip converter front end delivers averaged
  codes on SMP_SHUNT and SMP_SUPPLY at the end of each conversion phase.
*/
`timescale 1ns/1ps
`default_nettype none

module smr_top #(
  parameter int unsigned CT_CYC_0 = (smr_pkg::CT0_NS + smr_pkg::CLK_PERIOD_NS - 1)
                                    / smr_pkg::CLK_PERIOD_NS,
  parameter int unsigned CT_CYC_1 = (smr_pkg::CT1_NS + smr_pkg::CLK_PERIOD_NS - 1)
                                    / smr_pkg::CLK_PERIOD_NS,
  parameter int unsigned CT_CYC_2 = (smr_pkg::CT2_NS + smr_pkg::CLK_PERIOD_NS - 1)
                                    / smr_pkg::CLK_PERIOD_NS,
  parameter int unsigned CT_CYC_3 = (smr_pkg::CT3_NS + smr_pkg::CLK_PERIOD_NS - 1)
                                    / smr_pkg::CLK_PERIOD_NS,
  parameter int unsigned CT_CYC_4 = (smr_pkg::CT4_NS + smr_pkg::CLK_PERIOD_NS - 1)
                                    / smr_pkg::CLK_PERIOD_NS,
  parameter int unsigned CT_CYC_5 = (smr_pkg::CT5_NS + smr_pkg::CLK_PERIOD_NS - 1)
                                    / smr_pkg::CLK_PERIOD_NS,
  parameter int unsigned CT_CYC_6 = (smr_pkg::CT6_NS + smr_pkg::CLK_PERIOD_NS - 1)
                                    / smr_pkg::CLK_PERIOD_NS,
  parameter int unsigned CT_CYC_7 = (smr_pkg::CT7_NS + smr_pkg::CLK_PERIOD_NS - 1)
                                    / smr_pkg::CLK_PERIOD_NS
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [15:0] SMP_SHUNT,
  input wire logic [14:0] SMP_SUPPLY,
  output logic CONV_SHUNT_ACTIVE,
  output logic CONV_BUS_ACTIVE,
  input wire logic LNK_CLK,
  input wire logic LNK_RST_B,
  input wire logic LNK_REQ,
  input wire logic LNK_WRITE,
  input wire logic [7:0] LNK_ADDR,
  input wire logic [15:0] LNK_WDATA,
  output logic LNK_BUSY,
  output logic LNK_DONE,
  output logic [15:0] LNK_RDATA,
  output logic ALERT_O,
  output logic ALERT_OE_B
);
  import smr_pkg::*;

  // Link-domain request holding registers and handshake.
  logic lk_req_tgl_reg;
  logic lk_write_reg;
  logic [7:0] lk_addr_reg;
  logic [15:0] lk_wdata_reg;
  logic lk_ak_s1_reg;
  logic lk_ak_s2_reg;
  logic lk_ak_s3_reg;

  // System-domain handshake and register file.
  logic sy_rq_s1_reg;
  logic sy_rq_s2_reg;
  logic sy_rq_s3_reg;
  logic sy_ack_tgl_reg;
  logic [15:0] sy_rdata_reg;
  logic [15:0] config_reg;
  logic [15:0] calib_reg;
  logic [15:0] mask_en_reg;
  logic [15:0] limit_reg;
  logic [15:0] shunt_reg;
  logic [15:0] supply_reg;
  logic [15:0] current_reg;
  logic [15:0] power_reg;
  logic aff_reg;
  logic conv_ready_flag_reg;
  logic ovf_reg;
  logic trig_pend_reg;
  smr_state_e state_reg;
  logic [CNT_W-1:0] timer_reg;

  logic sy_access;
  logic cfg_wr;
  logic mask_rd;
  logic [2:0] mode;
  logic phase_end;
  logic eval_now;
  logic limit_hit;
  logic alert_active;
  logic signed [31:0] cur_prod;
  logic signed [31:0] cur_scaled;
  logic [15:0] cur_mag;
  logic [31:0] pow_prod;
  logic [31:0] pow_scaled;

  // Time code to cycle count; the minus one makes the phase last the full count.
  function automatic logic [CNT_W-1:0] ct_cycles(input logic [2:0] code);
    logic [CNT_W-1:0] c;
    c = CNT_W'(CT_CYC_0 - 1);
    case (code)
      3'h1: c = CNT_W'(CT_CYC_1 - 1);
      3'h2: c = CNT_W'(CT_CYC_2 - 1);
      3'h3: c = CNT_W'(CT_CYC_3 - 1);
      3'h4: c = CNT_W'(CT_CYC_4 - 1);
      3'h5: c = CNT_W'(CT_CYC_5 - 1);
      3'h6: c = CNT_W'(CT_CYC_6 - 1);
      3'h7: c = CNT_W'(CT_CYC_7 - 1);
      default: c = CNT_W'(CT_CYC_0 - 1);
    endcase
    return c;
  endfunction

  // Link side: one request at a time; fields are held stable until the answer.
  always_ff @(posedge LNK_CLK) begin
    if (!LNK_RST_B) begin
      lk_req_tgl_reg <= 1'b0;
      lk_write_reg <= 1'b0;
      lk_addr_reg <= 8'h00;
      lk_wdata_reg <= ZERO16;
      LNK_BUSY <= 1'b0;
      LNK_DONE <= 1'b0;
      LNK_RDATA <= ZERO16;
    end else begin
      LNK_DONE <= 1'b0;
      if (LNK_REQ && !LNK_BUSY) begin
        lk_req_tgl_reg <= ~lk_req_tgl_reg;
        lk_write_reg <= LNK_WRITE;
        lk_addr_reg <= LNK_ADDR;
        lk_wdata_reg <= LNK_WDATA;
        LNK_BUSY <= 1'b1;
      end else if (lk_ak_s2_reg ^ lk_ak_s3_reg) begin
        // The system word has been still since the ack toggled.
        LNK_RDATA <= sy_rdata_reg;
        LNK_DONE <= 1'b1;
        LNK_BUSY <= 1'b0;
      end
    end
  end

  // Link side: acknowledge toggle synchroniser.
  always_ff @(posedge LNK_CLK) begin
    if (!LNK_RST_B) begin
      lk_ak_s1_reg <= 1'b0;
      lk_ak_s2_reg <= 1'b0;
      lk_ak_s3_reg <= 1'b0;
    end else begin
      lk_ak_s1_reg <= sy_ack_tgl_reg;
      lk_ak_s2_reg <= lk_ak_s1_reg;
      lk_ak_s3_reg <= lk_ak_s2_reg;
    end
  end

  // System side: request toggle synchroniser.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      sy_rq_s1_reg <= 1'b0;
      sy_rq_s2_reg <= 1'b0;
      sy_rq_s3_reg <= 1'b0;
    end else begin
      sy_rq_s1_reg <= lk_req_tgl_reg;
      sy_rq_s2_reg <= sy_rq_s1_reg;
      sy_rq_s3_reg <= sy_rq_s2_reg;
    end
  end

  // Access decode; the link fields are held while the toggle is in flight.
  assign sy_access = sy_rq_s2_reg ^ sy_rq_s3_reg;
  assign cfg_wr = sy_access && lk_write_reg && (lk_addr_reg == REG_CONFIG);
  assign mask_rd = sy_access && !lk_write_reg && (lk_addr_reg == REG_MASK);
  assign mode = config_reg[CFG_MODE_LSB +: 3];
  assign phase_end = (timer_reg == '0);
  assign eval_now = (state_reg == ST_EVAL);

  // Read mux and acknowledge; unmapped pointers read zero.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      sy_rdata_reg <= ZERO16;
      sy_ack_tgl_reg <= 1'b0;
    end else if (sy_access) begin
      sy_ack_tgl_reg <= ~sy_ack_tgl_reg;
      case (lk_addr_reg)
        REG_CONFIG: sy_rdata_reg <= config_reg & CFG_WMASK;
        REG_SHUNT: sy_rdata_reg <= shunt_reg;
        REG_SUPPLY: sy_rdata_reg <= supply_reg;
        REG_POWER: sy_rdata_reg <= power_reg;
        REG_CURRENT: sy_rdata_reg <= current_reg;
        REG_CALIB: sy_rdata_reg <= calib_reg;
        REG_MASK: sy_rdata_reg <= (mask_en_reg & MSK_WMASK)
                                  | (16'(aff_reg) << MSK_AFF)
                                  | (16'(conv_ready_flag_reg) << MSK_CONV_READY_FLAG)
                                  | (16'(ovf_reg) << MSK_OVF);
        REG_LIMIT: sy_rdata_reg <= limit_reg;
        default: sy_rdata_reg <= ZERO16;
      endcase
    end
  end

  // Writable registers; only the documented bits are stored.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      config_reg <= CFG_RESET;
      calib_reg <= ZERO16;
      mask_en_reg <= ZERO16;
      limit_reg <= ZERO16;
    end else if (sy_access && lk_write_reg) begin
      case (lk_addr_reg)
        REG_CONFIG: config_reg <= lk_wdata_reg & CFG_WMASK;
        REG_CALIB: calib_reg <= lk_wdata_reg & CAL_WMASK;
        REG_MASK: mask_en_reg <= lk_wdata_reg & MSK_WMASK;
        REG_LIMIT: limit_reg <= lk_wdata_reg;
        default: limit_reg <= limit_reg;
      endcase
    end
  end

  // Conversion sequencer. A configuration write halts the running cycle and
  // restarts from idle, so no result mixes old and new settings.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      state_reg <= ST_IDLE;
      timer_reg <= '0;
      trig_pend_reg <= 1'b0;
    end else if (cfg_wr) begin
      state_reg <= ST_IDLE;
      timer_reg <= '0;
      // Power-down codes never arm a triggered run.
      trig_pend_reg <= (lk_wdata_reg[CFG_MODE_LSB +: 2] != 2'b00);
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if ((mode[MODE_CONT_BIT] || trig_pend_reg) && mode[1:0] != 2'b00) begin
            trig_pend_reg <= 1'b0;
            if (mode[MODE_SHUNT_BIT]) begin
              state_reg <= ST_SHUNT;
              timer_reg <= ct_cycles(config_reg[CFG_SCT_LSB +: 3]);
            end else begin
              state_reg <= ST_BUS;
              timer_reg <= ct_cycles(config_reg[CFG_BCT_LSB +: 3]);
            end
          end
        end
        ST_SHUNT: begin
          if (!phase_end) begin
            timer_reg <= timer_reg - 1'b1;
          end else if (mode[MODE_BUS_BIT]) begin
            state_reg <= ST_BUS;
            timer_reg <= ct_cycles(config_reg[CFG_BCT_LSB +: 3]);
          end else begin
            state_reg <= ST_CALC_I;
          end
        end
        ST_BUS: begin
          if (!phase_end) begin
            timer_reg <= timer_reg - 1'b1;
          end else begin
            state_reg <= ST_CALC_I;
          end
        end
        ST_CALC_I: state_reg <= ST_CALC_P;
        ST_CALC_P: state_reg <= ST_EVAL;
        ST_EVAL: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Phase indications to the front end, registered.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      CONV_SHUNT_ACTIVE <= 1'b0;
      CONV_BUS_ACTIVE <= 1'b0;
    end else begin
      CONV_SHUNT_ACTIVE <= (state_reg == ST_SHUNT) && !cfg_wr;
      CONV_BUS_ACTIVE <= (state_reg == ST_BUS) && !cfg_wr;
    end
  end

  // Arithmetic. The calibration top bit is masked at write, so it never
  // enters the product; the power divide folds in the fixed 25x weight.
  assign cur_prod = $signed(shunt_reg) * $signed({1'b0, calib_reg[14:0]});
  assign cur_scaled = cur_prod >>> CUR_SHIFT;
  assign cur_mag = current_reg[15] ? 16'(-current_reg) : current_reg;
  assign pow_prod = {16'h0000, cur_mag} * {16'h0000, supply_reg};
  assign pow_scaled = pow_prod / POW_DIV;

  // Result registers. The front end already averages, so what arrives at a
  // phase end is the averaged code and is stored as is.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      shunt_reg <= ZERO16;
      supply_reg <= ZERO16;
      current_reg <= ZERO16;
      power_reg <= ZERO16;
    end else if (!cfg_wr) begin
      if (state_reg == ST_SHUNT && phase_end) begin
        shunt_reg <= SMP_SHUNT;
      end
      if (state_reg == ST_BUS && phase_end) begin
        supply_reg <= {1'b0, SMP_SUPPLY};
      end
      if (state_reg == ST_CALC_I) begin
        current_reg <= cur_scaled[15:0];
      end
      if (state_reg == ST_CALC_P) begin
        power_reg <= pow_scaled[15:0];
      end
    end
  end

  // Highest enabled limit function alone is compared, on fresh results.
  always_comb begin
    limit_hit = 1'b0;
    if (mask_en_reg[MSK_SOL]) begin
      limit_hit = $signed(shunt_reg) > $signed(limit_reg);
    end else if (mask_en_reg[MSK_SUL]) begin
      limit_hit = $signed(shunt_reg) < $signed(limit_reg);
    end else if (mask_en_reg[MSK_BOL]) begin
      limit_hit = supply_reg > limit_reg;
    end else if (mask_en_reg[MSK_BUL]) begin
      limit_hit = supply_reg < limit_reg;
    end else if (mask_en_reg[MSK_POL]) begin
      limit_hit = power_reg > limit_reg;
    end
  end

  // Alert function flag: set by a hit at evaluation, which wins over any
  // clear; cleared by a mask read when latched, by a clean cycle otherwise.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      aff_reg <= 1'b0;
    end else if (eval_now && limit_hit) begin
      aff_reg <= 1'b1;
    end else if (mask_en_reg[MSK_LEN] && mask_rd) begin
      aff_reg <= 1'b0;
    end else if (!mask_en_reg[MSK_LEN] && eval_now) begin
      aff_reg <= 1'b0;
    end
  end

  // Ready flag: set when all arithmetic is done; mask read or a config write
  // clears it; a completion in the same cycle keeps it set over a mask read, not over a config write.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      conv_ready_flag_reg <= 1'b0;
    end else if (eval_now && !cfg_wr) begin
      conv_ready_flag_reg <= 1'b1;
    end else if (mask_rd || cfg_wr) begin
      conv_ready_flag_reg <= 1'b0;
    end
  end

  // Overflow flag follows each arithmetic pass; a result that does not fit
  // sixteen bits marks current and power as suspect.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ovf_reg <= 1'b0;
    end else if (state_reg == ST_CALC_I && !cfg_wr) begin
      ovf_reg <= (cur_scaled > 32'sh0000_7FFF) || (cur_scaled < -32'sh0000_8000);
    end else if (state_reg == ST_CALC_P && !cfg_wr) begin
      ovf_reg <= ovf_reg || (pow_scaled > 32'h0000_FFFF);
    end
  end

  assign alert_active = aff_reg || (mask_en_reg[MSK_CONV_READY_ALERT_EN] && conv_ready_flag_reg);

  // Open-drain alert pin: enable low means the pin is pulled low. Normal
  // polarity pulls low while active; inverted releases while active.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ALERT_O <= 1'b0;
      ALERT_OE_B <= 1'b1;
    end else begin
      ALERT_O <= 1'b0;
      ALERT_OE_B <= mask_en_reg[MSK_ALERT_POLARITY] ? alert_active : !alert_active;
    end
  end

endmodule

`default_nettype wire

// ---- smr_pkg.sv ----
/*
  Shared constants for the shunt monitor result and alert block: register
  pointers, field positions, reset values, conversion times and the
  sequencer state encoding.
  Assumes a 50 MHz system clock; every timing count derives from it.
*/
package smr_pkg;

  // Register pointers as seen by the two-wire engine.
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_SHUNT = 8'h01;
  localparam logic [7:0] REG_SUPPLY = 8'h02;
  localparam logic [7:0] REG_POWER = 8'h03;
  localparam logic [7:0] REG_CURRENT = 8'h04;
  localparam logic [7:0] REG_CALIB = 8'h05;
  localparam logic [7:0] REG_MASK = 8'h06;
  localparam logic [7:0] REG_LIMIT = 8'h07;

  // Reset values and writable-bit masks.
  localparam logic [15:0] CFG_RESET = 16'h4127;
  localparam logic [15:0] CFG_WMASK = 16'h7FFF;
  localparam logic [15:0] CAL_WMASK = 16'h7FFF;
  localparam logic [15:0] MSK_WMASK = 16'hFC03;
  localparam logic [15:0] ZERO16 = 16'h0000;

  // Configuration field positions.
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SCT_LSB = 3;
  localparam int CFG_BCT_LSB = 6;
  localparam int MODE_SHUNT_BIT = 0;
  localparam int MODE_BUS_BIT = 1;
  localparam int MODE_CONT_BIT = 2;

  // Mask/enable field positions.
  localparam int MSK_SOL = 15;
  localparam int MSK_SUL = 14;
  localparam int MSK_BOL = 13;
  localparam int MSK_BUL = 12;
  localparam int MSK_POL = 11;
  localparam int MSK_CONV_READY_ALERT_EN = 10;
  localparam int MSK_AFF = 4;
  localparam int MSK_CONV_READY_FLAG = 3;
  localparam int MSK_OVF = 2;
  localparam int MSK_ALERT_POLARITY = 1;
  localparam int MSK_LEN = 0;

  // Conversion times in nanoseconds, code 0 to code 7.
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CT0_NS = 140000;
  localparam int unsigned CT1_NS = 204000;
  localparam int unsigned CT2_NS = 332000;
  localparam int unsigned CT3_NS = 588000;
  localparam int unsigned CT4_NS = 1100000;
  localparam int unsigned CT5_NS = 2116000;
  localparam int unsigned CT6_NS = 4156000;
  localparam int unsigned CT7_NS = 8244000;
  localparam int CNT_W = 20;

  // Arithmetic scaling: current drops 11 bits, power divides by 20000.
  localparam int CUR_SHIFT = 11;
  localparam logic [31:0] POW_DIV = 32'h0000_4E20;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SHUNT = 6'b000010,
    ST_BUS = 6'b000100,
    ST_CALC_I = 6'b001000,
    ST_CALC_P = 6'b010000,
    ST_EVAL = 6'b100000
  } smr_state_e;

endpackage

// ---- smr_checker.sv ----
/*
  Port checks for the shunt monitor top: reset state, conversion phases,
  alert pin and the link register handshake.
  Assumes it is bound to smr_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module smr_checker (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic CONV_SHUNT_ACTIVE,
  input wire logic CONV_BUS_ACTIVE,
  input wire logic LNK_CLK,
  input wire logic LNK_RST_B,
  input wire logic LNK_REQ,
  input wire logic LNK_BUSY,
  input wire logic LNK_DONE,
  input wire logic [15:0] LNK_RDATA,
  input wire logic ALERT_O,
  input wire logic ALERT_OE_B
);
  // The pin is open drain, so only its enable may carry the alert.
  property p_alert_data;
    @(posedge SYS_CLK) disable iff (!RST_B) ALERT_O == 1'b0;
  endproperty
  a_alert_data: assert property (p_alert_data) else $error("Alert data not low");
  // Leaving reset the pin is released and no phase runs yet.
  property p_sys_reset;
    @(posedge SYS_CLK) disable iff (!RST_B)
      $rose(RST_B) |-> ALERT_OE_B && !CONV_SHUNT_ACTIVE && !CONV_BUS_ACTIVE;
  endproperty
  a_sys_reset: assert property (p_sys_reset) else $error("Bad state after reset");
  // One sequencer state means the two phases never overlap.
  property p_one_phase;
    @(posedge SYS_CLK) disable iff (!RST_B) !(CONV_SHUNT_ACTIVE && CONV_BUS_ACTIVE);
  endproperty
  a_one_phase: assert property (p_one_phase) else $error("Both phases active");
  // Link side leaves reset quiet.
  property p_lnk_reset;
    @(posedge LNK_CLK) disable iff (!LNK_RST_B)
      $rose(LNK_RST_B) |-> !LNK_BUSY && !LNK_DONE && LNK_RDATA == 16'h0000;
  endproperty
  a_lnk_reset: assert property (p_lnk_reset) else $error("Link port not idle");
  // An accepted request turns busy on at the next edge.
  property p_take;
    @(posedge LNK_CLK) disable iff (!LNK_RST_B) LNK_REQ && !LNK_BUSY |=> LNK_BUSY;
  endproperty
  a_take: assert property (p_take) else $error("Request not taken");
  // Busy never rises without a request.
  property p_no_spurious;
    @(posedge LNK_CLK) disable iff (!LNK_RST_B) !LNK_REQ && !LNK_BUSY |=> !LNK_BUSY;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("Busy without request");
  // The answer comes within a bounded number of link cycles.
  property p_answer;
    @(posedge LNK_CLK) disable iff (!LNK_RST_B) $rose(LNK_BUSY) |-> ##[1:12] LNK_DONE;
  endproperty
  a_answer: assert property (p_answer) else $error("No answer in time");
  // Busy ends only at the answer edge, and the answer lasts one cycle.
  property p_busy_end;
    @(posedge LNK_CLK) disable iff (!LNK_RST_B) $fell(LNK_BUSY) |-> LNK_DONE ##1 !LNK_DONE;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("Busy ended without answer");
  // Read data holds between answers, so a slow host still sees it.
  property p_rdata_hold;
    @(posedge LNK_CLK) disable iff (!LNK_RST_B) !LNK_DONE |-> $stable(LNK_RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("Read data moved");
endmodule
`default_nettype wire

// ---- smr_host_model.sv ----
/*
  Host side of the link register port: one whole-word access at a time.
  Assumes the bench calls access only after both resets are released.
*/
`timescale 1ns/1ps
`default_nettype none
module smr_host_model (
  input wire logic lnk_clk,
  output logic lnk_req,
  output logic lnk_write,
  output logic [7:0] lnk_addr,
  output logic [15:0] lnk_wdata,
  input wire logic lnk_done,
  input wire logic [15:0] lnk_rdata
);
  int stall;
  // Idle values at time zero; stall makes the host slow on demand.
  initial begin
    lnk_req = 1'b0;
    lnk_write = 1'b0;
    lnk_addr = 8'h00;
    lnk_wdata = 16'h0000;
    stall = 0;
  end
  // A request pulse of one cycle, then a bounded wait for the answer.
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
    ok = 1'b0;
    q = 16'h0000;
    repeat (stall) @(posedge lnk_clk);
    @(posedge lnk_clk);
    lnk_req <= 1'b1;
    lnk_write <= wr;
    lnk_addr <= a;
    lnk_wdata <= d; // Whole word; the top bit of a calibration value is ignored.
    @(posedge lnk_clk);
    lnk_req <= 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge lnk_clk);
      #1;
      if (lnk_done === 1'b1) begin
        ok = 1'b1;
        q = lnk_rdata;
      end
    end
    // Released lines show the inverse so stale values cannot pass.
    lnk_addr <= ~a;
    lnk_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- smr_top_tb.sv ----
/*
  Self-checking bench for smr_top with a host model and a result model.
  Assumes short conversion counts set through the top's parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module smr_top_tb;
  import smr_pkg::*;
  logic sys_clk, rst_b, lnk_clk, lnk_rst_b, req, wr, busy, done, sh_on, bus_on, al_o, al_oe_b;
  logic ok, act;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, shunt, q, cal, lim, msk;
  logic [14:0] supply;
  logic [15:0] cfg;
  int errors, compares, seed, s0, b0;
  int cycles = 0, sh_cnt = 0, bus_cnt = 0;
  longint cur_e, pow_e;
  // Only codes 0 to 4 are shortened; codes 5 to 7 would outlast the run, so no
  // scenario selects them.
  smr_top #(.CT_CYC_0(4), .CT_CYC_1(7), .CT_CYC_2(10), .CT_CYC_3(13), .CT_CYC_4(16))
    u_smr_top (.SYS_CLK(sys_clk),
    .RST_B(rst_b), .SMP_SHUNT(shunt), .SMP_SUPPLY(supply), .CONV_SHUNT_ACTIVE(sh_on),
    .CONV_BUS_ACTIVE(bus_on), .LNK_CLK(lnk_clk), .LNK_RST_B(lnk_rst_b), .LNK_REQ(req),
    .LNK_WRITE(wr), .LNK_ADDR(addr), .LNK_WDATA(wdata), .LNK_BUSY(busy), .LNK_DONE(done),
    .LNK_RDATA(rdata), .ALERT_O(al_o), .ALERT_OE_B(al_oe_b));
  smr_host_model u_smr_host_model (.lnk_clk(lnk_clk), .lnk_req(req), .lnk_write(wr),
    .lnk_addr(addr), .lnk_wdata(wdata), .lnk_done(done), .lnk_rdata(rdata));
  // Clocks of unrelated phase: 20 ns system, 48 ns link.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    lnk_clk = 1'b0;
    #7;
    forever #24 lnk_clk = ~lnk_clk;
  end
  // Phase cycle counters and the hang limit.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    sh_cnt <= sh_cnt + sh_on;
    bus_cnt <= bus_cnt + bus_on;
    if (cycles == 30000) begin
      errors = errors + 1;
      conclude();
    end
  end
  task automatic conclude;
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    u_smr_host_model.access(1'b0, a, 16'h0000, q, ok);
    check(ok, 1'b1);
  endtask
  task automatic wrr(input logic [7:0] a, input logic [15:0] d);
    u_smr_host_model.access(1'b1, a, d, q, ok);
    check(ok, 1'b1);
  endtask
  // Only the highest enabled limit function is compared.
  function automatic logic hit(logic [15:0] m, logic [15:0] l, logic [15:0] s,
                               logic [15:0] b, logic [15:0] p);
    if (m[MSK_SOL]) return $signed(s) > $signed(l);
    if (m[MSK_SUL]) return $signed(s) < $signed(l);
    if (m[MSK_BOL]) return b > l;
    if (m[MSK_BUL]) return b < l;
    if (m[MSK_POL]) return p > l;
    return 1'b0;
  endfunction
  initial begin
    seed = 52374;
    errors = 0;
    compares = 0;
    rst_b = 1'b0;
    lnk_rst_b = 1'b0;
    shunt = 16'h0000;
    supply = 15'h0000;
    repeat (2) @(posedge sys_clk);
    repeat (2) @(posedge lnk_clk);
    @(posedge sys_clk) rst_b <= 1'b1;
    @(posedge lnk_clk) lnk_rst_b <= 1'b1;
    // Reset values, a write to a read-only place and an unmapped read.
    rd(REG_CONFIG);
    check(q, CFG_RESET);
    wrr(REG_SHUNT, 16'h1234);
    for (int a = 1; a < 9; a++) begin
      rd(a == 8 ? 8'h20 : a[7:0]);
      check(q & 16'hFFF7, ZERO16);
    end
    wrr(REG_CALIB, 16'hFFFF);
    rd(REG_CALIB);
    check(q, 16'h7FFF);
    $display("Test reset values done");
    // Random inputs; calibration kept small so no product overflows.
    for (int i = 0; i < 24; i++) begin
      cal = $random(seed) & 16'h07FF;
      lim = $random(seed);
      msk = $random(seed) & 16'hF802;
      u_smr_host_model.stall = $random(seed) & 3;
      @(posedge sys_clk);
      shunt <= $random(seed);
      supply <= $random(seed);
      wrr(REG_CALIB, cal);
      wrr(REG_LIMIT, lim);
      wrr(REG_MASK, msk);
      repeat (100) @(posedge sys_clk);
      cur_e = longint'($signed(shunt)) * longint'(cal);
      cur_e = $signed(16'(cur_e >>> CUR_SHIFT));
      pow_e = ((cur_e < 0 ? -cur_e : cur_e) * longint'(supply)) / longint'(POW_DIV);
      act = hit(msk, lim, shunt, {1'b0, supply}, pow_e[15:0]);
      rd(REG_SHUNT);
      check(q, shunt);
      rd(REG_SUPPLY);
      check(q, {1'b0, supply});
      rd(REG_CURRENT);
      check(q, cur_e[15:0]);
      rd(REG_POWER);
      check(q, pow_e[15:0]);
      check(al_oe_b, msk[MSK_ALERT_POLARITY] ? act : !act);
      rd(REG_MASK);
      check(q & 16'hFFF7, (msk & MSK_WMASK) | {11'h000, act, 4'h0});
    end
    u_smr_host_model.stall = 0;
    $display("Test results and alerts done");
    // Latched alert survives the cleared fault until the mask read.
    @(posedge sys_clk) shunt <= 16'h0100;
    wrr(REG_LIMIT, 16'h0000);
    wrr(REG_MASK, 16'h8001);
    repeat (100) @(posedge sys_clk);
    check(al_oe_b, 1'b0);
    @(posedge sys_clk) shunt <= 16'hFF00;
    repeat (100) @(posedge sys_clk);
    check(al_oe_b, 1'b0);
    rd(REG_MASK);
    check(q & 16'hFFF7, 16'h8011);
    repeat (100) @(posedge sys_clk);
    check(al_oe_b, 1'b1);
    wrr(REG_MASK, 16'h0400);
    repeat (100) @(posedge sys_clk);
    check(al_oe_b, 1'b0);
    $display("Test latch and ready alert done");
    // Every mode; both time codes follow the low two mode bits, so only the
    // shortened codes ever run.
    for (int m = 0; m < 8; m++) begin
      wrr(REG_CONFIG, 16'h0000);
      repeat (40) @(posedge sys_clk);
      s0 = sh_cnt;
      b0 = bus_cnt;
      cfg = {7'h00, 1'b0, m[1:0], 1'b0, m[1:0], m[2:0]};
      wrr(REG_CONFIG, cfg);
      repeat (150) @(posedge sys_clk);
      rd(REG_CONFIG);
      check(q, cfg);
      check(sh_cnt > s0, m[0]);
      check(bus_cnt > b0, m[1]);
      if (!m[2] && m[0])
        check(16'(sh_cnt - s0), 16'(4 + 3 * m));
      if (!m[2] && m[1])
        check(16'(bus_cnt - b0), 16'(4 + 3 * m));
    end
    $display("Test modes and times done");
    conclude();
  end
endmodule
bind smr_top smr_checker u_smr_checker (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
  .CONV_SHUNT_ACTIVE(CONV_SHUNT_ACTIVE), .CONV_BUS_ACTIVE(CONV_BUS_ACTIVE),
  .LNK_CLK(LNK_CLK), .LNK_RST_B(LNK_RST_B), .LNK_REQ(LNK_REQ), .LNK_BUSY(LNK_BUSY),
  .LNK_DONE(LNK_DONE), .LNK_RDATA(LNK_RDATA), .ALERT_O(ALERT_O), .ALERT_OE_B(ALERT_OE_B));
`default_nettype wire
